// ---- serial_sram_spi_access.v ----
// SPI slave front end and array of a serial SRAM
`timescale 1ns/10ps
`include "sram_spi_defs.vh"
module serial_sram_spi_access #(
	parameter ADDR_W = `ADDR_BITS,
	parameter DEPTH  = `FIFO_DEPTH
) (
	input  wire       clk_sys,
	input  wire       arst_n,
	input  wire       spi_cs_n,
	input  wire       spi_sck,
	input  wire       spi_si,
	output wire       spi_so,
	output wire       spi_so_oe,
	output wire [1:0] access_mode,
	output wire       wr_stall
);
	// Pointer width follows the queue depth
	function integer ptr_bits;
		input integer n;
		integer k;
		begin
			ptr_bits = 0;
			for (k = 1; k < n; k = k * 2)
				ptr_bits = ptr_bits + 1;
		end
	endfunction

	localparam FIFO_AW = ptr_bits(DEPTH);

	localparam ST_INSTR = 3'd0;
	localparam ST_ADDR  = 3'd1;
	localparam ST_RDAT  = 3'd2;
	localparam ST_WDAT  = 3'd3;
	localparam ST_MRD   = 3'd4;
	localparam ST_MWR   = 3'd5;
	localparam ST_IDLE  = 3'd6;

	reg [2:0]        cs_sy_reg;
	reg [2:0]        sck_sy_reg;
	reg [1:0]        si_sy_reg;
	reg [2:0]        state_reg;
	reg [`BIT_CNT_W-1:0] bit_reg;
	reg [`INSTR_BITS-1:0] instr_reg;
	reg [`ADDR_FIELD-1:0] shift_reg;
	reg [ADDR_W-1:0] addr_reg;
	reg [1:0]        mode_reg;
	reg [7:0]        dout_reg;
	reg              so_reg;
	reg              oe_reg;
	reg              byte_done_reg;
	reg [7:0]        mem [0:(1<<ADDR_W)-1];
	wire             sel;
	wire             rise;
	wire             fall;
	wire [7:0]       in_byte;
	wire             f_valid;
	wire [ADDR_W+7:0] f_data;
	wire             f_in_ready;
	wire             push;

	// Next address under the current mode
	function [ADDR_W-1:0] next_addr;
		input [ADDR_W-1:0] a;
		input [1:0]        m;
		begin
			if (m == `MODE_PAGE)
				next_addr = {a[ADDR_W-1:`PAGE_BITS],
					a[`PAGE_BITS-1:0] + 1'b1};
			else
				next_addr = a + 1'b1;
		end
	endfunction

	// Second stage feeds select and data directly; edge detection also uses third stage
	assign sel  = !cs_sy_reg[1];
	assign rise = sck_sy_reg[1] && !sck_sy_reg[2];
	assign fall = !sck_sy_reg[1] && sck_sy_reg[2];
	assign in_byte = {shift_reg[6:0], si_sy_reg[1]};
	assign spi_so = so_reg;
	assign spi_so_oe = oe_reg;
	assign access_mode = mode_reg;
	assign wr_stall = !f_in_ready;
	assign push = sel && rise && state_reg == ST_WDAT &&
		bit_reg == `BIT_LAST && !byte_done_reg;

	// Writes queue through FIFO so array port is shared with reads
	// Full queue drops further bytes; wr_stall tells the system side
	sram_fifo #(.WIDTH(ADDR_W+8), .DEPTH(DEPTH), .AW(FIFO_AW)) u_fifo (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.in_valid  (push),
		.in_ready  (f_in_ready),
		.in_data   ({addr_reg, in_byte}),
		.out_valid (f_valid),
		.out_ready (1'b1),
		.out_data  (f_data)
	);

	always @(posedge clk_sys) begin
		if (f_valid)
			mem[f_data[ADDR_W+7:8]] <= f_data[7:0];
	end

	// Two stages before any logic; third stage only for edges
	// Idle levels at reset, so no false edge after release
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cs_sy_reg  <= 3'b111;
			sck_sy_reg <= 3'b000;
			si_sy_reg  <= 2'b00;
		end else begin
			cs_sy_reg  <= {cs_sy_reg[1:0], spi_cs_n};
			sck_sy_reg <= {sck_sy_reg[1:0], spi_sck};
			si_sy_reg  <= {si_sy_reg[0], spi_si};
		end
	end

	// Link clock must stay slow enough for three-stage sampling
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_reg     <= ST_INSTR;
			bit_reg       <= {`BIT_CNT_W{1'b0}};
			instr_reg     <= {`INSTR_BITS{1'b0}};
			shift_reg     <= {`ADDR_FIELD{1'b0}};
			addr_reg      <= {ADDR_W{1'b0}};
			mode_reg      <= `MODE_RESET;
			dout_reg      <= 8'h00;
			so_reg        <= 1'b0;
			oe_reg        <= 1'b0;
			byte_done_reg <= 1'b0;
		end else begin
			if (!sel) begin
				state_reg     <= ST_INSTR;
				bit_reg       <= {`BIT_CNT_W{1'b0}};
				oe_reg        <= 1'b0;
				byte_done_reg <= 1'b0;
			end else if (rise) begin
				shift_reg <= {shift_reg[`ADDR_FIELD-2:0], si_sy_reg[1]};
				bit_reg   <= bit_reg + 1'b1;
				case (state_reg)
				ST_INSTR: begin
					if (bit_reg == `BIT_LAST) begin
						instr_reg <= in_byte;
						bit_reg   <= {`BIT_CNT_W{1'b0}};
						case (in_byte)
						`OP_READ, `OP_WRITE: state_reg <= ST_ADDR;
						`OP_RD_MODE: begin
							state_reg <= ST_MRD;
							dout_reg  <= {mode_reg, 6'h00};
						end
						`OP_WR_MODE: state_reg <= ST_MWR;
						default: state_reg <= ST_IDLE;
						endcase
					end
				end
				ST_ADDR: begin
					if (bit_reg == `ADDR_LAST) begin
						addr_reg <= {shift_reg[ADDR_W-2:0], si_sy_reg[1]};
						dout_reg <= mem[{shift_reg[ADDR_W-2:0],
							si_sy_reg[1]}];
						bit_reg  <= {`BIT_CNT_W{1'b0}};
						state_reg <= (instr_reg == `OP_READ) ?
							ST_RDAT : ST_WDAT;
					end
				end
				ST_RDAT, ST_WDAT: begin
					if (bit_reg == `BIT_LAST) begin
						bit_reg <= {`BIT_CNT_W{1'b0}};
						if (mode_reg == `MODE_BYTE)
							byte_done_reg <= 1'b1;
						addr_reg <= next_addr(addr_reg, mode_reg);
					end
				end
				ST_MWR: begin
					if (bit_reg == `BIT_LAST) begin
						mode_reg <= {in_byte[`MODE_HI_BIT],
							in_byte[`MODE_LO_BIT]};
						state_reg <= ST_IDLE;
					end
				end
				ST_MRD: begin
					if (bit_reg == `BIT_LAST)
						bit_reg <= {`BIT_CNT_W{1'b0}};
				end
				default: state_reg <= ST_IDLE;
				endcase
			end else if (fall) begin
				if ((state_reg == ST_RDAT || state_reg == ST_MRD) &&
					!byte_done_reg) begin
					oe_reg <= 1'b1;
					so_reg <= dout_reg[3'd7 - bit_reg[2:0]];
					if (bit_reg == 5'h00 && state_reg == ST_RDAT)
						dout_reg <= mem[addr_reg];
				end else begin
					oe_reg <= 1'b0;
				end
			end
		end
	end
endmodule

// ---- sram_spi_defs.vh ----
// Constants for the serial SRAM SPI access block
`ifndef SRAM_SPI_DEFS_VH
`define SRAM_SPI_DEFS_VH
`define OP_READ        8'h03
`define OP_WRITE       8'h02
`define OP_RD_MODE     8'h05
`define OP_WR_MODE     8'h01
`define MODE_BYTE      2'b00
`define MODE_SEQ       2'b01
`define MODE_PAGE      2'b10
`define MODE_RESET     2'b01
`define MODE_HI_BIT    7
`define MODE_LO_BIT    6
`define ADDR_BITS      17
`define PAGE_BITS      5
`define ADDR_FIELD     24
`define INSTR_BITS     8
`define BIT_CNT_W      5
`define BIT_LAST       5'h07
`define ADDR_LAST      5'h17
`define FIFO_DEPTH     32
`endif

// ---- sram_fifo.v ----
// Write data FIFO between the serial front end and the array
`timescale 1ns/10ps
module sram_fifo #(
	parameter WIDTH = 25,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             clk_sys,
	input  wire             arst_n,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_reg;
	reg [AW:0]      rd_reg;
	wire            full;
	wire            empty;

	assign empty = (wr_reg == rd_reg);
	assign full = (wr_reg[AW] != rd_reg[AW]) &&
		(wr_reg[AW-1:0] == rd_reg[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_reg[AW-1:0]];

	always @(posedge clk_sys) begin
		if (in_valid && !full)
			mem[wr_reg[AW-1:0]] <= in_data;
	end

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wr_reg <= {(AW+1){1'b0}};
			rd_reg <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full)
				wr_reg <= wr_reg + 1'b1;
			if (out_ready && !empty)
				rd_reg <= rd_reg + 1'b1;
		end
	end
endmodule

// ---- sram_spi_checks_properties.sv ----
// Port checks for the serial SRAM access block
`timescale 1ns/10ps
module sram_spi_checks (
	input wire       clk_sys,
	input wire       arst_n,
	input wire       spi_cs_n,
	input wire       spi_sck,
	input wire       spi_so,
	input wire       spi_so_oe,
	input wire [1:0] access_mode
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	sequence idle_s; spi_cs_n [*5]; endsequence
	sequence high_s; spi_sck [*6]; endsequence
	AST_OE_DROP: assert property (idle_s |-> !spi_so_oe)
		else $error("output enabled while deselected");
	AST_OE_LIVE: assert property (spi_so_oe |-> !$past(spi_cs_n, 5))
		else $error("output enable outlived select");
	AST_MODE_QUIET: assert property (spi_cs_n [*6] |-> $stable(access_mode))
		else $error("mode moved while deselected");
	AST_SO_HOLD: assert property (high_s |-> $stable(spi_so))
		else $error("output moved in clock high");
	AST_SO_LOW: assert property ($changed(spi_so) |-> !$past(spi_sck))
		else $error("output moved after rising edge");
	AST_OE_RISE: assert property ($rose(spi_so_oe) |-> !spi_sck && !spi_cs_n)
		else $error("output enable rose at wrong time");
	AST_MODE_RST: assert property ($rose(arst_n) |-> access_mode == 2'b01)
		else $error("mode not sequential after reset");
	AST_MODE_EDGE: assert property ($changed(access_mode) |-> spi_sck)
		else $error("mode moved away from rising edge");
endmodule
bind serial_sram_spi_access sram_spi_checks i_chk (.clk_sys(clk_sys),
	.arst_n(arst_n), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
	.spi_so(spi_so), .spi_so_oe(spi_so_oe), .access_mode(access_mode));

// ---- spi_host_model.sv ----
// Host side of the serial bus
`timescale 1ns/10ps
module spi_host_model (
	output reg  cs_n,
	output reg  sck,
	output reg  si,
	input  wire so
);
	integer i;
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	task start;
		cs_n = 1'b0;
		#80;
	endtask
	// Released line shows inverse, not a stale bit
	task stop;
		cs_n = 1'b1;
		si = ~si;
		#80;
	endtask
	task xb(input [7:0] tx, input integer n, output [7:0] rx);
		for (i = 7; i > 7 - n; i = i - 1) begin
			si = tx[i];
			#80 sck = 1'b1;
			rx[i] = so;
			#80 sck = 1'b0;
		end
	endtask
endmodule

// ---- serial_sram_spi_access_tb.sv ----
// Self-checking bench for the serial SRAM access block
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module serial_sram_spi_access_tb;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	wire         cs_n, sck, si, so, oe;
	wire  [1:0]  mode;
	wire         stall;
	int          num_errors = 0;
	int          num_checks = 0;
	int          cyc = 0;
	logic [7:0]  r;
	logic [1:0]  m_tab [3] = '{2'b01, 2'b10, 2'b00};
	logic [16:0] a_tab [3] = '{17'h1_FFFF, 17'h0_003F, 17'h1_FFFF};
	logic [16:0] n_tab [3] = '{17'h0_0000, 17'h0_0020, 17'h0_0000};
	logic [7:0]  e_tab [3] = '{8'h30, 8'h31, 8'h30};
	spi_host_model i_host (.cs_n(cs_n), .sck(sck), .si(si),
		.so(oe ? so : 1'bz));
	serial_sram_spi_access i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
		.spi_cs_n(cs_n), .spi_sck(sck), .spi_si(si), .spi_so(so),
		.spi_so_oe(oe), .access_mode(mode), .wr_stall(stall));
	always #5 clk_sys = ~clk_sys;
	// Whole run is near 9700 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	task finish_test;
		if (num_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task hdr(input [7:0] c, input [16:0] a, input [6:0] t);
		i_host.start();
		i_host.xb(c, 8, r);
		i_host.xb({t, a[16]}, 8, r);
		i_host.xb(a[15:8], 8, r);
		i_host.xb(a[7:0], 8, r);
	endtask
	task rd(input [16:0] a);
		hdr(8'h03, a, 7'h00);
		i_host.xb(8'h00, 8, r);
		i_host.stop();
	endtask
	task wm(input [1:0] m);
		i_host.start();
		i_host.xb(8'h01, 8, r);
		i_host.xb({m, 6'h00}, 8, r);
		i_host.stop();
		i_host.start();
		i_host.xb(8'h05, 8, r);
		i_host.xb(8'h00, 8, r);
		i_host.stop();
	endtask
	initial begin
		repeat (16) @(negedge clk_sys);
		arst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		`CHK("mode_rst", 2'b01, mode)
		for (int k = 0; k < 3; k++) begin
			wm(m_tab[k]);
			`CHK("mode", m_tab[k], mode)
			`CHK("mode_rd", {m_tab[k], 6'h00}, r)
			hdr(8'h02, a_tab[k], 7'h7F);
			i_host.xb(8'(8'hC0 + k), 8, r);
			i_host.xb(8'(8'h30 + k), 8, r);
			i_host.stop();
			rd(a_tab[k]);
			`CHK("rd_first", 8'(8'hC0 + k), r)
			`CHK("stall", 1'b0, stall)
			rd(n_tab[k]);
			`CHK("rd_next", e_tab[k], r)
		end
		// Partial byte at deselect must be dropped
		wm(2'b01);
		hdr(8'h02, 17'h0_0000, 7'h00);
		i_host.xb(8'hEE, 4, r);
		i_host.stop();
		rd(17'h0_0000);
		`CHK("abort", 8'h30, r)
		finish_test();
	end
endmodule
